// ---- pkg/ciau_pkg.sv ----
// Summary of operation
// RULE1 - A operand is a_source_register, or the zero-extended register field when literal set
// RULE2 - B operand always comes from b_source_register
// RULE3 - Unit bits: 1 adder, 2 compare, 4 logical, 8 reserved, 0 gives all ones
// RULE4 - Several unit bits set give the bitwise AND of selected unit outputs
// RULE5 - Logical unit is per-bit mux of function bits indexed by A,B; bit 4 ignored
// RULE6 - Adder: bit 4 complements A, bit 1 enables trap, bit 0 is carry in
// RULE7 - Enabled overflow raises the overflow trap in the writeback stage
// RULE8 - Compare result: sign bit is relation, all other bits one
// RULE9 - Compare function: top bit one, three sense bits, bottom bit carry in
// RULE10 - Equal signs use sign of B minus A; differing signs use b_sign_bit
// RULE11 - Compare codes 1A,1B,15,14 unsigned and 1E,1F,11,10 signed
// RULE12 - Logical codes 8 AND,1 NOR,E OR,6 XOR,A B,C A,9 EQV and the rest
// RULE13 - Result computed in compute stage and held for the writeback stage
package ciau_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REGNUM_W = 6;
  localparam int unsigned UNIT_W = 4;
  localparam int unsigned FUNC_W = 5;
  // Unit field bit positions
  localparam int unsigned UNIT_ADD = 0;
  localparam int unsigned UNIT_CMP = 1;
  localparam int unsigned UNIT_LOG = 2;
  localparam int unsigned UNIT_RSV = 3;
  // Adder function bits
  localparam int unsigned FN_COMP_A = 4;
  localparam int unsigned FN_TRAP = 1;
  localparam int unsigned FN_CIN = 0;
  // Compare sense bits
  localparam int unsigned FN_SENSE_11 = 3;
  localparam int unsigned FN_SENSE_DIFF = 2;
  localparam int unsigned FN_SENSE_00 = 1;
  // Compare codes
  localparam logic [4:0] CMP_LTU = 5'h1A;
  localparam logic [4:0] CMP_LEU = 5'h1B;
  localparam logic [4:0] CMP_GTU = 5'h15;
  localparam logic [4:0] CMP_GEU = 5'h14;
  localparam logic [4:0] CMP_LT = 5'h1E;
  localparam logic [4:0] CMP_LE = 5'h1F;
  localparam logic [4:0] CMP_GT = 5'h11;
  localparam logic [4:0] CMP_GE = 5'h10;
  // Logical codes, low four bits
  localparam logic [3:0] LOG_AND = 4'h8;
  localparam logic [3:0] LOG_NOR = 4'h1;
  localparam logic [3:0] LOG_OR = 4'hE;
  localparam logic [3:0] LOG_XOR = 4'h6;
  localparam logic [3:0] LOG_PASS_B = 4'hA;
  localparam logic [3:0] LOG_PASS_A = 4'hC;
  localparam logic [3:0] LOG_EQV = 4'h9;
  localparam logic [3:0] LOG_NOT_B = 4'h5;
  localparam logic [3:0] LOG_NOT_A = 4'h3;
  localparam logic [3:0] LOG_ZERO = 4'h0;
  localparam logic [3:0] LOG_ONE = 4'hF;
  localparam logic [3:0] LOG_B_ANDN_A = 4'h2;
  localparam logic [3:0] LOG_A_ANDN_B = 4'h4;
  localparam logic [3:0] LOG_NAND = 4'h7;
  // Reset values
  localparam logic [31:0] RESULT_RST = 32'h0000_0000;
  localparam logic [5:0] DEST_RST = 6'h00;
  localparam logic VALID_RST = 1'b0;
  localparam logic TRAP_RST = 1'b0;
endpackage : ciau_pkg

// ---- hw/ciau_alu.sv ----
`timescale 1ns/1ps
module ciau_alu (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Compute stage instruction
  input wire logic issue_valid_i,
  input wire logic literal_sel_i,
  input wire logic [5:0] a_field_i,
  input wire logic [5:0] dest_i,
  input wire logic [3:0] unit_i,
  input wire logic [4:0] func_i,
  // Register file operands
  input wire logic [31:0] a_source_register_i,
  input wire logic [31:0] b_source_register_i,
  // Writeback stage results
  output logic writeback_valid_o,
  output logic [5:0] writeback_dest_o,
  output logic [31:0] result_register_o,
  output logic overflow_trap_o
);

  logic [31:0] a_op;
  logic [31:0] b_op;
  logic [31:0] add_res;
  logic add_ovf;
  logic [31:0] cmp_res;
  logic [31:0] log_res;
  logic [31:0] alu_res;
  logic trap_now;

  // Operand select
  always_comb begin
    if (literal_sel_i) begin
      a_op = {26'h000_0000, a_field_i}; // RULE1
    end else begin
      a_op = a_source_register_i; // RULE1
    end
    b_op = b_source_register_i; // RULE2
  end

  // Adder; subtract forms B minus A since the A side is complemented
  always_comb begin
    logic [31:0] a_src;
    a_src = '0;
    if (func_i[ciau_pkg::FN_COMP_A]) begin
      a_src = ~a_op; // RULE6
    end else begin
      a_src = a_op;
    end
    add_res = a_src + b_op + {31'h0000_0000, func_i[ciau_pkg::FN_CIN]}; // RULE6
    add_ovf = (a_src[31] == b_op[31]) && (add_res[31] != b_op[31]);
  end

  // Comparison from the B minus A difference and b_sign_bit
  always_comb begin
    logic [31:0] diff;
    logic b_sign_bit;
    logic rel;
    diff = '0;
    b_sign_bit = b_op[31];
    rel = 1'b0;
    diff = b_op + ~a_op + {31'h0000_0000, func_i[ciau_pkg::FN_CIN]}; // RULE9
    if (a_op[31] != b_op[31]) begin
      rel = b_sign_bit ^ func_i[ciau_pkg::FN_SENSE_DIFF]; // RULE10
    end else if (a_op[31]) begin
      rel = diff[31] ^ func_i[ciau_pkg::FN_SENSE_11]; // RULE10
    end else begin
      rel = diff[31] ^ func_i[ciau_pkg::FN_SENSE_00]; // RULE10
    end
    cmp_res = {rel, 31'h7FFF_FFFF}; // RULE8
  end

  // Logical unit: per-bit four-input mux, function bit 4 unused
  for (genvar i = 0; i < 32; i++) begin : g_log
    assign log_res[i] = func_i[{a_op[i], b_op[i]}]; // RULE5
  end

  // Unit combine; reserved unit bit contributes all ones
  always_comb begin
    alu_res = 32'hFFFF_FFFF; // RULE3
    if (unit_i[ciau_pkg::UNIT_ADD]) begin
      alu_res = alu_res & add_res; // RULE4
    end
    if (unit_i[ciau_pkg::UNIT_CMP]) begin
      alu_res = alu_res & cmp_res; // RULE4
    end
    if (unit_i[ciau_pkg::UNIT_LOG]) begin
      alu_res = alu_res & log_res; // RULE4
    end
    trap_now = issue_valid_i && unit_i[ciau_pkg::UNIT_ADD] && func_i[ciau_pkg::FN_TRAP] && add_ovf; // RULE7
  end

  // Pipeline: compute -> memory stage -> writeback stage
  logic mem_valid_q, mem_valid_d;
  logic [5:0] mem_dest_q, mem_dest_d;
  logic [31:0] mem_res_q, mem_res_d;
  logic mem_trap_q, mem_trap_d;
  logic wb_valid_d;
  logic [5:0] wb_dest_d;
  logic [31:0] wb_res_d;
  logic wb_trap_d;

  // Next values; result held across the memory stage
  always_comb begin
    mem_valid_d = issue_valid_i;
    mem_dest_d = dest_i;
    mem_res_d = alu_res; // RULE13
    mem_trap_d = trap_now;
    wb_valid_d = mem_valid_q;
    wb_dest_d = mem_dest_q;
    wb_res_d = mem_res_q; // RULE13
    wb_trap_d = mem_trap_q; // RULE7
  end

  // Stage registers
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      mem_valid_q <= ciau_pkg::VALID_RST;
      mem_dest_q <= ciau_pkg::DEST_RST;
      mem_res_q <= ciau_pkg::RESULT_RST;
      mem_trap_q <= ciau_pkg::TRAP_RST;
      writeback_valid_o <= ciau_pkg::VALID_RST;
      writeback_dest_o <= ciau_pkg::DEST_RST;
      result_register_o <= ciau_pkg::RESULT_RST;
      overflow_trap_o <= ciau_pkg::TRAP_RST;
    end else begin
      mem_valid_q <= mem_valid_d;
      mem_dest_q <= mem_dest_d;
      mem_res_q <= mem_res_d;
      mem_trap_q <= mem_trap_d;
      writeback_valid_o <= wb_valid_d;
      writeback_dest_o <= wb_dest_d;
      result_register_o <= wb_res_d;
      overflow_trap_o <= wb_trap_d;
    end
  end

  // Checks; results land two edges after issue
  sequence s_issue_log(logic [3:0] code);
    issue_valid_i && unit_i == 4'h4 && func_i[3:0] == code;
  endsequence

  sequence s_issue_cmp(logic [4:0] code);
    issue_valid_i && unit_i == 4'h2 && func_i == code;
  endsequence

  // Trap absent in the memory stage unless an older trap sits there, then shown in writeback
  sequence s_trap_late;
    overflow_trap_o == $past(trap_now, 2) ##1 overflow_trap_o && writeback_valid_o;
  endsequence

  a_literal_operand: assert property (@(posedge clk_i) disable iff (reset_i) // RULE1
    issue_valid_i && literal_sel_i && unit_i == 4'h4 && func_i[3:0] == 4'hC
    |-> ##2 result_register_o == {26'h000_0000, $past(a_field_i, 2)})
    else $error("literal A operand wrong");

  a_b_operand: assert property (@(posedge clk_i) disable iff (reset_i) // RULE2
    s_issue_log(ciau_pkg::LOG_PASS_B) |-> ##2 result_register_o == $past(b_source_register_i, 2))
    else $error("B operand wrong");

  a_unit_none: assert property (@(posedge clk_i) disable iff (reset_i) // RULE3
    issue_valid_i && unit_i[2:0] == 3'h0 |-> ##2 writeback_valid_o && result_register_o == 32'hFFFF_FFFF)
    else $error("unit zero not all ones");

  a_unit_and: assert property (@(posedge clk_i) disable iff (reset_i) // RULE4
    issue_valid_i && unit_i[2:0] == 3'h5 |-> ##2 result_register_o == ($past(add_res, 2) & $past(log_res, 2)))
    else $error("multi unit not ANDed");

  a_logic_xor: assert property (@(posedge clk_i) disable iff (reset_i) // RULE12
    s_issue_log(ciau_pkg::LOG_XOR) |-> ##2 result_register_o == ($past(a_op, 2) ^ $past(b_op, 2)))
    else $error("logical xor wrong");

  a_logic_nand: assert property (@(posedge clk_i) disable iff (reset_i) // RULE5
    s_issue_log(ciau_pkg::LOG_NAND) |-> ##2 result_register_o == ~($past(a_op, 2) & $past(b_op, 2)))
    else $error("logical nand wrong");

  a_add_sub: assert property (@(posedge clk_i) disable iff (reset_i) // RULE6
    issue_valid_i && unit_i == 4'h1 && func_i == 5'h11
    |-> ##2 result_register_o == 32'($past(b_op, 2) - $past(a_op, 2)) && !overflow_trap_o)
    else $error("subtract wrong");

  a_trap_stage: assert property (@(posedge clk_i) disable iff (reset_i) // RULE7
    trap_now |-> ##1 s_trap_late)
    else $error("trap not in writeback stage");

  a_cmp_ltu: assert property (@(posedge clk_i) disable iff (reset_i) // RULE11
    s_issue_cmp(ciau_pkg::CMP_LTU)
    |-> ##2 result_register_o == {($past(a_op, 2) < $past(b_op, 2)), 31'h7FFF_FFFF})
    else $error("unsigned less wrong");

  a_cmp_ge: assert property (@(posedge clk_i) disable iff (reset_i) // RULE10
    s_issue_cmp(ciau_pkg::CMP_GE)
    |-> ##2 result_register_o == {($signed($past(a_op, 2)) >= $signed($past(b_op, 2))), 31'h7FFF_FFFF})
    else $error("signed greater-equal wrong");

  a_cmp_low_ones: assert property (@(posedge clk_i) disable iff (reset_i) // RULE8
    issue_valid_i && unit_i == 4'h2 && func_i[4] |-> ##2 result_register_o[30:0] == 31'h7FFF_FFFF)
    else $error("compare low bits not ones");

  a_cmp_lt: assert property (@(posedge clk_i) disable iff (reset_i) // RULE11
    s_issue_cmp(ciau_pkg::CMP_LT)
    |-> ##2 result_register_o == {($signed($past(a_op, 2)) < $signed($past(b_op, 2))), 31'h7FFF_FFFF})
    else $error("signed less wrong");

  a_cmp_leu: assert property (@(posedge clk_i) disable iff (reset_i) // RULE9
    s_issue_cmp(ciau_pkg::CMP_LEU)
    |-> ##2 result_register_o == {($past(a_op, 2) <= $past(b_op, 2)), 31'h7FFF_FFFF})
    else $error("unsigned less-equal wrong");

  a_add_plain: assert property (@(posedge clk_i) disable iff (reset_i) // RULE6
    issue_valid_i && unit_i == 4'h1 && func_i == 5'h00
    |-> ##2 result_register_o == 32'($past(a_op, 2) + $past(b_op, 2)))
    else $error("add wrong");

  a_trap_off: assert property (@(posedge clk_i) disable iff (reset_i) // RULE7
    issue_valid_i && !(unit_i[0] && func_i[1]) |-> ##2 !overflow_trap_o)
    else $error("trap raised while disabled");

  a_logic_and: assert property (@(posedge clk_i) disable iff (reset_i) // RULE12
    s_issue_log(ciau_pkg::LOG_AND) |-> ##2 result_register_o == ($past(a_op, 2) & $past(b_op, 2)))
    else $error("logical and wrong");

  a_result_held: assert property (@(posedge clk_i) disable iff (reset_i) // RULE13
    issue_valid_i |-> ##2 writeback_valid_o && writeback_dest_o == $past(dest_i, 2)
      && result_register_o == $past(alu_res, 2))
    else $error("result not held to writeback");

endmodule : ciau_alu

// ---- verif/ciau_wb_sink.sv ----
`timescale 1ns/1ps
module ciau_wb_sink (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Writeback stage
  input wire logic valid_i,
  input wire logic [5:0] dest_i,
  input wire logic [31:0] result_i,
  input wire logic trap_i,
  // Writes seen
  output logic [31:0] count_o
);
  logic [31:0] res_q [64];
  logic trap_q [64];
  // Register file write port; stale entries stay X so a lost write shows
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      count_o <= 32'h0000_0000;
    end else if (valid_i) begin
      res_q[dest_i] <= result_i;
      trap_q[dest_i] <= trap_i;
      count_o <= count_o + 32'h0000_0001;
    end
  end
endmodule : ciau_wb_sink

// ---- verif/cpu_integer_alu_unit_bench.sv ----
`timescale 1ns/1ps
module cpu_integer_alu_unit_bench;
  logic clk_i = 1'b0, reset_i = 1'b1, issue_valid_i = 1'b0, literal_sel_i = 1'b0;
  logic [5:0] a_field_i = 6'h00, dest_i = 6'h00;
  logic [3:0] unit_i = 4'h0;
  logic [4:0] func_i = 5'h00;
  logic [31:0] a_source_register_i = 32'h0, b_source_register_i = 32'h0, sink_count;
  logic writeback_valid_o, overflow_trap_o;
  logic [5:0] writeback_dest_o;
  logic [31:0] result_register_o;
  logic [31:0] exp_r [64];
  logic exp_t [64];
  int errors = 0, samples_checked = 0, cycles = 0, issued = 0;
  ciau_alu dut (.clk_i(clk_i), .reset_i(reset_i), .issue_valid_i(issue_valid_i), .literal_sel_i(literal_sel_i),
    .a_field_i(a_field_i), .dest_i(dest_i), .unit_i(unit_i), .func_i(func_i),
    .a_source_register_i(a_source_register_i), .b_source_register_i(b_source_register_i),
    .writeback_valid_o(writeback_valid_o), .writeback_dest_o(writeback_dest_o),
    .result_register_o(result_register_o), .overflow_trap_o(overflow_trap_o));
  ciau_wb_sink sink (.clk_i(clk_i), .reset_i(reset_i), .valid_i(writeback_valid_o), .dest_i(writeback_dest_o),
    .result_i(result_register_o), .trap_i(overflow_trap_o), .count_o(sink_count));
  // 8 ns clock and a hang guard
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      errors = errors + 1;
      complete_run();
    end
  end
  // Reference model: {trap, result}
  function automatic logic [32:0] ref_op(logic lit, logic [5:0] af, logic [3:0] un, logic [4:0] fn,
      logic [31:0] a, logic [31:0] b);
    logic [31:0] x, xs, s, d, l, r;
    logic rel;
    x = lit ? {26'h0000000, af} : a;
    xs = fn[4] ? ~x : x;
    s = xs + b + {31'h0, fn[0]};
    d = b + ~x + {31'h0, fn[0]};
    rel = (x[31] == b[31]) ? (d[31] ^ (x[31] ? fn[3] : fn[1])) : (b[31] ^ fn[2]);
    for (int i = 0; i < 32; i++) l[i] = fn[{x[i], b[i]}];
    r = 32'hFFFF_FFFF;
    if (un[0]) r = r & s;
    if (un[1]) r = r & {rel, 31'h7FFF_FFFF};
    if (un[2]) r = r & l;
    return {un[0] & fn[1] & (xs[31] == b[31]) & (s[31] != xs[31]), r};
  endfunction : ref_op
  // Relation named by each compare code, in code order
  function automatic logic rel_of(int k, logic [31:0] a, logic [31:0] b);
    case (k)
      0: return a < b;
      1: return a <= b;
      2: return a > b;
      3: return a >= b;
      4: return $signed(a) < $signed(b);
      5: return $signed(a) <= $signed(b);
      6: return $signed(a) > $signed(b);
      default: return $signed(a) >= $signed(b);
    endcase
  endfunction : rel_of
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    samples_checked = samples_checked + 1;
    if (seen !== want) begin
      errors = errors + 1;
      $display("[FAIL] %0t seen %h want %h", $time, seen, want);
    end
  endtask : check
  // One instruction per edge, back to back
  task automatic issue(logic lit, logic [5:0] af, logic [3:0] un, logic [4:0] fn, logic [31:0] a, logic [31:0] b,
      logic [5:0] d);
    {exp_t[d], exp_r[d]} = ref_op(lit, af, un, fn, a, b);
    issue_valid_i <= 1'b1;
    {literal_sel_i, a_field_i, unit_i, func_i, dest_i} <= {lit, af, un, fn, d};
    a_source_register_i <= a;
    b_source_register_i <= b;
    @(posedge clk_i);
    issued = issued + 1;
  endtask : issue
  // Two-stage latency plus the sink's write edge; the last write lands after the third edge
  task automatic verify(int n);
    issue_valid_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    for (int d = 0; d < n; d++) begin
      check(sink.res_q[d], exp_r[d]);
      check({31'h0, sink.trap_q[d]}, {31'h0, exp_t[d]});
    end
  endtask : verify
  task automatic t_logic();
    for (int f = 0; f < 16; f++) issue(1'b0, 6'h00, 4'h4, {f[0], f[3:0]}, 32'hF0F0_3C3C, 32'hFF00_5A5A, f[5:0]);
    verify(16);
    check(sink.res_q[8], 32'hF000_1818);
    check(sink.res_q[6], 32'h0FF0_6666);
  endtask : t_logic
  task automatic t_compare();
    logic [4:0] c [8];
    logic [31:0] p [10];
    c = '{ciau_pkg::CMP_LTU, ciau_pkg::CMP_LEU, ciau_pkg::CMP_GTU, ciau_pkg::CMP_GEU,
      ciau_pkg::CMP_LT, ciau_pkg::CMP_LE, ciau_pkg::CMP_GT, ciau_pkg::CMP_GE};
    p = '{32'h5, 32'h9, 32'h9, 32'h9, 32'hFFFF_FFF0, 32'h3, 32'h3, 32'hFFFF_FFF0, 32'hFFFF_FFF0, 32'hFFFF_FFF5};
    for (int i = 0; i < 40; i++) issue(1'b0, 6'h00, 4'h2, c[i % 8], p[2 * (i / 8)], p[2 * (i / 8) + 1], i[5:0]);
    verify(40);
    // Judge each code by the relation it names, not by sense bits
    for (int i = 0; i < 40; i++) begin
      check(sink.res_q[i], {rel_of(i % 8, p[2 * (i / 8)], p[2 * (i / 8) + 1]), 31'h7FFF_FFFF});
    end
  endtask : t_compare
  // Overflow with and without trap enable, trap kept when units are ANDed
  task automatic t_adder();
    issue(1'b0, 6'h00, 4'h1, 5'h00, 32'h1234_5678, 32'h1111_1111, 6'h00);
    issue(1'b0, 6'h00, 4'h1, 5'h11, 32'h0000_0005, 32'h0000_0003, 6'h01);
    issue(1'b0, 6'h00, 4'h1, 5'h02, 32'h7FFF_FFFF, 32'h0000_0001, 6'h02);
    issue(1'b0, 6'h00, 4'h1, 5'h00, 32'h7FFF_FFFF, 32'h0000_0001, 6'h03);
    issue(1'b0, 6'h00, 4'h1, 5'h13, 32'h0000_0001, 32'h8000_0000, 6'h04);
    issue(1'b0, 6'h00, 4'h5, 5'h02, 32'h4000_0000, 32'h4000_0000, 6'h05);
    verify(6);
    check(sink.res_q[0], 32'h2345_6789);
    check(sink.res_q[1], 32'hFFFF_FFFE);
    check({28'h000_0000, sink.trap_q[2], sink.trap_q[3], sink.trap_q[4], sink.trap_q[5]}, 32'h0000_000B);
  endtask : t_adder
  task automatic t_units();
    logic [3:0] u [6];
    u = '{4'h0, 4'h8, 4'h3, 4'h6, 4'h7, 4'hF};
    for (int i = 0; i < 6; i++) issue(1'b0, 6'h00, u[i], 5'h0E, 32'h8000_00F3, 32'h0000_1234, i[5:0]);
    issue(1'b1, 6'h2A, 4'h4, 5'h0C, 32'hDEAD_0000, 32'h0000_0077, 6'h06);
    issue(1'b1, 6'h3F, 4'h1, 5'h00, 32'hFFFF_FFFF, 32'h0000_0100, 6'h07);
    verify(8);
    check(sink.res_q[6], 32'h0000_002A);
    check(sink.res_q[7], 32'h0000_013F);
    check(sink.res_q[1], 32'hFFFF_FFFF);
  endtask : t_units
  task automatic complete_run();
    if (errors == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run
  // Main sequence
  initial begin
    repeat (6) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    t_logic();
    t_compare();
    t_adder();
    t_units();
    check(sink_count, 32'(issued));
    complete_run();
  end
endmodule : cpu_integer_alu_unit_bench
